// ---- timer_io_control_ac.v ----
// function select decode for general registers a and c of channel 0 and register a of channel 1
`include "timer_io_ac_map.vh"

module timer_io_control_ac #(
	parameter CNT_W = 16
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// function selects and mode
	input wire [3:0] ch0_reg_a_function_sel,
	input wire [3:0] ch0_reg_c_function_sel,
	input wire [3:0] ch1_reg_a_function_sel,
	input wire buffer_a_enable,
	// counters and compare matches
	input wire [CNT_W-1:0] ch0_counter,
	input wire [CNT_W-1:0] ch1_counter,
	input wire ch0_match_a,
	input wire ch0_match_c,
	input wire ch1_match_a,
	// pins
	input wire ch0_pin_a_in,
	output wire ch0_pin_a_out,
	output wire ch0_pin_a_oe,
	input wire ch0_pin_c_in,
	output wire ch0_pin_c_out,
	output wire ch0_pin_c_oe,
	input wire ch1_pin_a_in,
	output wire ch1_pin_a_out,
	output wire ch1_pin_a_oe,
	// captures
	output wire ch0_capture_a,
	output wire [CNT_W-1:0] ch0_general_register_a,
	output wire ch0_capture_c,
	output wire [CNT_W-1:0] ch0_general_register_c,
	output wire ch1_capture_a,
	output wire [CNT_W-1:0] ch1_general_register_a,
	// software wrote a forbidden code
	output wire setting_error
);

	// synchronised pin edges
	wire a0_rise;
	wire a0_fall;
	wire c0_rise;
	wire c0_fall;
	wire a1_rise;
	wire a1_fall;
	// decoded controls, one set per unit
	wire c0_live;
	wire a0_cmp;
	wire c0_cmp;
	wire a1_cmp;
	wire a0_hit;
	wire c0_hit;
	wire a1_hit;
	wire a0_fresh;
	wire c0_fresh;
	wire a1_fresh;
	// unit state
	reg [3:0] a0_sel_q;
	reg [3:0] c0_sel_q;
	reg [3:0] a1_sel_q;
	reg a0_oe_q;
	reg c0_oe_q;
	reg a1_oe_q;
	reg a0_out_q;
	reg c0_out_q;
	reg a1_out_q;
	reg a0_cap_q;
	reg c0_cap_q;
	reg a1_cap_q;
	reg [CNT_W-1:0] a0_val_q;
	reg [CNT_W-1:0] c0_val_q;
	reg [CNT_W-1:0] a1_val_q;
	reg a0_err_q;
	reg c0_err_q;
	reg a1_err_q;

	// compare codes: bit 3 clear and a nonzero action in bits 1..0
	function compare_code;
		input [3:0] code;
		begin
			compare_code = ~code[`SEL_MODE_BIT] & (code[1:0] != `ACT_NONE);
		end
	endfunction

	// capture codes 1000, 1001 and 101x pick which pin edges latch the counter
	function capture_hit;
		input [3:0] code;
		input rise;
		input fall;
		begin
			capture_hit = 1'b0;
			if (code[`SEL_MODE_BIT] && !code[`SEL_LEVEL_BIT]) begin
				if (code == `CAP_RISE) begin
					capture_hit = rise;
				end else if (code == `CAP_FALL) begin
					capture_hit = fall;
				end else begin
					capture_hit = rise | fall;
				end
			end
		end
	endfunction

	// codes 11xx: no capture and no drive, only the error flag
	function prohibited_code;
		input [3:0] code;
		begin
			prohibited_code = code[`SEL_MODE_BIT] & code[`SEL_LEVEL_BIT];
		end
	endfunction

	// next pin level; a fresh compare code wins over a match in the same cycle
	function next_level;
		input [3:0] code;
		input cmp;
		input fresh;
		input match;
		input level;
		begin
			next_level = level;
			if (!cmp) begin
				next_level = 1'b0;
			end else if (fresh) begin
				next_level = code[`SEL_LEVEL_BIT];
			end else if (match) begin
				case (code[1:0])
					`ACT_LOW: begin
						next_level = 1'b0;
					end
					`ACT_HIGH: begin
						next_level = 1'b1;
					end
					`ACT_TOGGLE: begin
						next_level = ~level;
					end
					default: begin
						next_level = level;
					end
				endcase
			end
		end
	endfunction

	// every pin passes its own three-stage synchroniser
	pin_unit u_sync_a0 (
		.clk(clk),
		.reset(reset),
		.pin_in(ch0_pin_a_in),
		.rise(a0_rise),
		.fall(a0_fall)
	);
	pin_unit u_sync_c0 (
		.clk(clk),
		.reset(reset),
		.pin_in(ch0_pin_c_in),
		.rise(c0_rise),
		.fall(c0_fall)
	);
	pin_unit u_sync_a1 (
		.clk(clk),
		.reset(reset),
		.pin_in(ch1_pin_a_in),
		.rise(a1_rise),
		.fall(a1_fall)
	);

	// compare and capture decode; register c goes quiet while it buffers a
	assign c0_live = ~buffer_a_enable;
	assign a0_cmp = compare_code(ch0_reg_a_function_sel);
	assign c0_cmp = c0_live & compare_code(ch0_reg_c_function_sel);
	assign a1_cmp = compare_code(ch1_reg_a_function_sel);
	assign a0_hit = capture_hit(ch0_reg_a_function_sel, a0_rise, a0_fall);
	assign c0_hit = c0_live & capture_hit(ch0_reg_c_function_sel, c0_rise, c0_fall);
	assign a1_hit = capture_hit(ch1_reg_a_function_sel, a1_rise, a1_fall);
	// initial level goes out on entry to compare, e.g. when buffering ends, or on a new code
	assign a0_fresh = a0_cmp & (~a0_oe_q | (ch0_reg_a_function_sel != a0_sel_q));
	assign c0_fresh = c0_cmp & (~c0_oe_q | (ch0_reg_c_function_sel != c0_sel_q));
	assign a1_fresh = a1_cmp & (~a1_oe_q | (ch1_reg_a_function_sel != a1_sel_q));

	// channel 0 register a: pin drive, capture latch and error flag
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			a0_sel_q <= `SEL_RESET;
			a0_oe_q <= 1'b0;
			a0_out_q <= 1'b0;
			a0_cap_q <= 1'b0;
			a0_val_q <= {CNT_W{1'b0}};
			a0_err_q <= 1'b0;
		end else begin
			a0_sel_q <= ch0_reg_a_function_sel;
			a0_oe_q <= a0_cmp;
			a0_out_q <= next_level(ch0_reg_a_function_sel, a0_cmp, a0_fresh,
				ch0_match_a, a0_out_q);
			a0_cap_q <= a0_hit;
			if (a0_hit) begin
				a0_val_q <= ch0_counter;
			end
			a0_err_q <= prohibited_code(ch0_reg_a_function_sel);
		end
	end

	// channel 0 register c: same job, silenced while it buffers register a
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			c0_sel_q <= `SEL_RESET;
			c0_oe_q <= 1'b0;
			c0_out_q <= 1'b0;
			c0_cap_q <= 1'b0;
			c0_val_q <= {CNT_W{1'b0}};
			c0_err_q <= 1'b0;
		end else begin
			c0_sel_q <= ch0_reg_c_function_sel;
			c0_oe_q <= c0_cmp;
			c0_out_q <= next_level(ch0_reg_c_function_sel, c0_cmp, c0_fresh,
				ch0_match_c, c0_out_q);
			c0_cap_q <= c0_hit;
			if (c0_hit) begin
				c0_val_q <= ch0_counter;
			end
			c0_err_q <= c0_live & prohibited_code(ch0_reg_c_function_sel);
		end
	end

	// channel 1 register a, same coding as channel 0
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			a1_sel_q <= `SEL_RESET;
			a1_oe_q <= 1'b0;
			a1_out_q <= 1'b0;
			a1_cap_q <= 1'b0;
			a1_val_q <= {CNT_W{1'b0}};
			a1_err_q <= 1'b0;
		end else begin
			a1_sel_q <= ch1_reg_a_function_sel;
			a1_oe_q <= a1_cmp;
			a1_out_q <= next_level(ch1_reg_a_function_sel, a1_cmp, a1_fresh,
				ch1_match_a, a1_out_q);
			a1_cap_q <= a1_hit;
			if (a1_hit) begin
				a1_val_q <= ch1_counter;
			end
			a1_err_q <= prohibited_code(ch1_reg_a_function_sel);
		end
	end

	// outputs straight from the unit registers
	assign ch0_pin_a_out = a0_out_q;
	assign ch0_pin_a_oe = a0_oe_q;
	assign ch0_pin_c_out = c0_out_q;
	assign ch0_pin_c_oe = c0_oe_q;
	assign ch1_pin_a_out = a1_out_q;
	assign ch1_pin_a_oe = a1_oe_q;
	assign ch0_capture_a = a0_cap_q;
	assign ch0_general_register_a = a0_val_q;
	assign ch0_capture_c = c0_cap_q;
	assign ch0_general_register_c = c0_val_q;
	assign ch1_capture_a = a1_cap_q;
	assign ch1_general_register_a = a1_val_q;

	// forbidden codes are flagged; c is exempt while buffering
	assign setting_error = a0_err_q | a1_err_q | c0_err_q;

endmodule // timer_io_control_ac

// ---- timer_io_ac_map.vh ----
// constants for the register a and c function select decode
`ifndef TIMER_IO_AC_MAP_VH
`define TIMER_IO_AC_MAP_VH

// field positions inside the 4-bit select
`define SEL_MODE_BIT 3
`define SEL_LEVEL_BIT 2
`define SEL_ACT_HI 1
`define SEL_ACT_LO 0

// reset value of every select field
`define SEL_RESET 4'h0

// compare actions held in bits 1..0
`define ACT_NONE 2'h0
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3

// capture codes
`define CAP_RISE 4'h8
`define CAP_FALL 4'h9

// depth of the pin input synchroniser
`define PIN_SYNC_STAGES 3

`endif

// ---- pin_unit.v ----
// one pin input: three-stage synchroniser and edge strobes for input capture
`include "timer_io_ac_map.vh"

module pin_unit (
	// clock and reset
	input wire clk,
	input wire reset,
	// pin
	input wire pin_in,
	// one-cycle strobes on a change of the agreed level
	output wire rise,
	output wire fall
);

	reg [`PIN_SYNC_STAGES-1:0] sync_q;
	reg level_q;
	wire agree;

	// three stage synchroniser; only stage two reads stage one
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_q <= {`PIN_SYNC_STAGES{1'b0}};
		end else begin
			sync_q <= {sync_q[1:0], pin_in};
		end
	end

	// a change counts once stages two and three agree, so a one-cycle runt is dropped
	assign agree = (sync_q[1] == sync_q[2]);

	// agreed level; resets low, the idle level of a released pin in this system
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			level_q <= 1'b0;
		end else if (agree) begin
			level_q <= sync_q[2];
		end
	end

	// edges of the agreed level, one cycle each
	assign rise = agree & sync_q[2] & ~level_q;
	assign fall = agree & ~sync_q[2] & level_q;

endmodule // pin_unit

// ---- timer_io_control_ac_sva.sv ----
// assertions on the a and c function select decode
module timer_io_control_ac_sva (
	// clock and reset
	input wire clk,
	input wire reset,
	// selects, mode and match
	input wire [3:0] ch0_reg_a_function_sel,
	input wire [3:0] ch1_reg_a_function_sel,
	input wire buffer_a_enable,
	input wire ch0_match_a,
	// pin drive and error flag
	input wire ch0_pin_a_out,
	input wire ch0_pin_a_oe,
	input wire ch0_pin_c_oe,
	input wire setting_error
);
	timeunit 1ns;
	timeprecision 1ns;
	// short aliases keep each property readable in one or two lines
	wire [3:0] s = ch0_reg_a_function_sel;
	wire c = !s[3] && s[1:0] != 2'h0, o = ch0_pin_a_out, m = ch0_match_a, e = ch0_pin_a_oe;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_oe_off: assert property (!c |=> !e) else $error("pin a driven");
	a_oe_on: assert property (c |=> e) else $error("pin a idle");
	a_init_level: assert property (c && $changed(s) |=> o == $past(s[2]))
		else $error("initial level");
	a_match_low: assert property (s == 4'h1 && m && $stable(s) |=> !o) else $error("low");
	// a match only acts once the pin is already driven; entry applies the initial level
	a_match_high: assert property (s == 4'h2 && m && e && $stable(s)
		|=> o) else $error("high");
	a_toggle_flip: assert property (c && e && s[1:0] == 2'h3 && m && $stable(s)
		|=> o != $past(o)) else $error("toggle");
	a_bad_code: assert property (ch1_reg_a_function_sel[3:2] == 2'h3 |=> setting_error)
		else $error("error flag");
	a_buffer_c: assert property (buffer_a_enable [*2] |-> !ch0_pin_c_oe) else $error("c pin");
	// main scenarios reached
	c_toggle: cover property (s == 4'h3 && m);
	c_buffer: cover property (buffer_a_enable && s == 4'h3);
	c_error: cover property (setting_error);
endmodule // timer_io_control_ac_sva

bind timer_io_control_ac timer_io_control_ac_sva chk_ac (.clk, .reset, .ch0_reg_a_function_sel,
	.ch1_reg_a_function_sel, .buffer_a_enable, .ch0_match_a, .ch0_pin_a_out, .ch0_pin_a_oe,
	.ch0_pin_c_oe, .setting_error);

// ---- ext_pin.sv ----
// outside world on the three timer pins: drives them whenever the device lets go
module ext_pin (
	// device enables and levels, outside level, resolved wires
	input wire [2:0] oe,
	input wire [2:0] out,
	input wire ext,
	output wire [2:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin = (oe & out) | (~oe & {3{ext}});
endmodule // ext_pin

// ---- timer_io_control_ac_bench.sv ----
// self-checking bench for the a and c function select decode
module timer_io_control_ac_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, bf = 0, ext = 0, mt = 0;
	logic [2:0] seen;
	logic [3:0] sel = 4'h0;
	logic [15:0] cnt = 16'h0, last = 16'h0;
	wire ao, ae, co, ce, bo, be, ca, cc, cb, err;
	wire [2:0] pin;
	wire [15:0] ra, rb, rc;
	int fail_count = 0, checks_done = 0, cyc = 0;
	// code, pin enable, initial level, level after one match, error flag
	logic [7:0] rows [16] = '{8'h00, 8'h18, 8'h2a, 8'h3a, 8'h40, 8'h5c, 8'h6e, 8'h7c,
		8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc1, 8'hd1, 8'he1, 8'hf1};
	// code, pin level then capture expected, counter
	logic [23:0] caps [6] = '{24'h831234, 24'h805555, 24'h926666, 24'h912222, 24'ha33333,
		24'hb14444};
	always #10 clk = ~clk;
	ext_pin px (.oe({be, ce, ae}), .out({bo, co, ao}), .ext(ext), .pin(pin));
	// one code feeds all selects, so both channels and register c move together
	timer_io_control_ac DUT (.clk(clk), .reset(reset), .ch0_reg_a_function_sel(sel),
		.ch0_reg_c_function_sel(sel), .ch1_reg_a_function_sel(sel), .buffer_a_enable(bf),
		.ch0_counter(cnt), .ch1_counter(cnt), .ch0_match_a(mt), .ch0_match_c(mt), .ch1_match_a(mt),
		.ch0_pin_a_in(pin[0]), .ch0_pin_a_out(ao), .ch0_pin_a_oe(ae), .ch0_pin_c_in(pin[1]),
		.ch0_pin_c_out(co), .ch0_pin_c_oe(ce), .ch1_pin_a_in(pin[2]), .ch1_pin_a_out(bo),
		.ch1_pin_a_oe(be), .ch0_capture_a(ca), .ch0_general_register_a(ra), .ch0_capture_c(cc),
		.ch0_general_register_c(rc), .ch1_capture_a(cb), .ch1_general_register_a(rb),
		.setting_error(err));
	task chk(input logic [47:0] g, input logic [47:0] e);
		checks_done++;
		if (g !== e) $display("mismatch at %0t got %h expected %h", $time, g, e);
		if (g !== e) fail_count++;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// the synchroniser delays a capture, so six edges are watched for the pulse
	task cap(input logic [23:0] k);
		seen = 0;
		sel = k[23:20];
		cnt = k[15:0];
		tick(2);
		ext = k[17];
		repeat (6) begin
			tick(1);
			seen |= {cb, cc, ca};
		end
		if (k[16]) last = k[15:0];
		// register c stays out of it while it buffers register a
		chk({seen, ra, rb}, {k[16], k[16] & ~bf, k[16], last, last});
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// reset, every code through the table, then captures and buffer mode
	initial begin
		tick(20);
		reset = 0;
		chk({ae, ao, err}, 17'h0);
		foreach (rows[i]) begin
			sel = 4'h0;
			tick(2);
			sel = rows[i][7:4];
			tick(2);
			chk({ae, ce, be}, {3{rows[i][3]}});
			chk({ao, co, bo, err}, {{3{rows[i][2]}}, rows[i][0]});
			mt = 1;
			tick(1);
			chk({ao, co, bo}, {3{rows[i][1]}});
			mt = 0;
		end
		$display("code table done");
		foreach (caps[i]) cap(caps[i]);
		bf = 1;
		cap(24'h837777);
		sel = 4'h3;
		tick(2);
		chk({ce, rc}, {1'b0, 16'h4444});
		$display("capture done");
		// a compare code standing while buffering must come alive when buffering ends
		sel = 4'h7;
		tick(2);
		chk({ce, co, ae, ao}, 4'h3);
		bf = 0;
		tick(2);
		chk({ce, co}, 2'h3);
		// reset in mid-run with a compare code standing, then release
		reset = 1;
		tick(1);
		chk({ae, ao, ce, co, err}, 5'h0);
		reset = 0;
		tick(1);
		chk({ae, ao, ce, co}, 4'hf);
		$display("reset done");
		summarize;
	end
	// the run needs about 165 cycles, so 2000 means a hang
	always @(posedge clk) if (++cyc == 2000) begin
		fail_count++;
		summarize;
	end
endmodule // timer_io_control_ac_bench
